/* File: hdl/ddr_frame_receiver.sv */
// serial frame receiver with register decode and an AHB-Lite status/control slave
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

// What this block does
// - shift bits in only while frame select is low; ignore data otherwise.
// - sample data and advance the shift register on each serial clock rise.
// - sixteen-bit shift word: control byte first, then data byte.
// - first received bit is bit 15, most significant first.
// - frame select rising after sixteen bits decodes control and executes the load.
// - each channel has an input register and a separate output register.
// - data byte is unsigned straight binary, 0 to 255.
// - reference selection taken from a control bit of every written word.
// - control bits: ref, unused, load-both, pd B, pd A, channel, function code.
// - function codes 00/01/10/11 load both outputs, one input, one output from its input, one output; load-both loads input and updates both outputs.
// - each power-down bit powers down its channel; register contents are kept.
// - reset clears input registers, output registers transparent until first write.
module ddr_frame_receiver (
    input  wire logic        clk,
    input  wire logic        rst,
    // serial pins
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        din,
    // converter side
    output logic [7:0]       dac_code_a,
    output logic [7:0]       dac_code_b,
    output logic             reference_select,
    output logic             power_down_chan_a,
    output logic             power_down_chan_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // pins pass two flops before use; sclk must stay below about clk/4
    logic [2:0] pin_raw;
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic [2:0] prev_ff;
    assign pin_raw = {din, sync_n, sclk};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    // idle pin levels, so no false frame edge follows reset
                    meta_ff[gi] <= ddr_pkg::RST_PIN_LEVEL[gi];
                    sync_ff[gi] <= ddr_pkg::RST_PIN_LEVEL[gi];
                    prev_ff[gi] <= ddr_pkg::RST_PIN_LEVEL[gi];
                end else begin
                    meta_ff[gi] <= pin_raw[gi];
                    sync_ff[gi] <= meta_ff[gi];
                    prev_ff[gi] <= sync_ff[gi];
                end
            end
        end
    endgenerate

    logic sclk_rise;
    logic sync_rise;
    logic sync_fall;
    logic frame_open;
    assign sclk_rise  = sync_ff[0] & ~prev_ff[0];
    assign sync_rise  = sync_ff[1] & ~prev_ff[1];
    assign sync_fall  = ~sync_ff[1] & prev_ff[1];
    assign frame_open = ~sync_ff[1];

    // ------------------------------------------------------------------
    // register bus address phase
    // ------------------------------------------------------------------
    logic       wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic       addr_ok;
    assign addr_ok   = hsel & hready & (htrans == ddr_pkg::HTRANS_NONSEQ);
    assign hreadyout = 1'h1;
    assign hresp     = 1'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_ff <= 1'h0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    logic wr_ctrl;
    logic wr_status;
    assign wr_ctrl   = wr_pend_ff & (wr_addr_ff == ddr_pkg::OFS_CTRL);
    assign wr_status = wr_pend_ff & (wr_addr_ff == ddr_pkg::OFS_STATUS);

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic rx_en_ff;
    logic soft_rst;
    // soft reset is a write strobe only, it is never stored
    assign soft_rst = wr_ctrl & hwdata[ddr_pkg::CTRL_SOFT_RST];

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_en_ff <= ddr_pkg::RST_RX_EN;
        end else if (wr_ctrl) begin
            rx_en_ff <= hwdata[ddr_pkg::CTRL_RX_EN];
        end
    end

    // ------------------------------------------------------------------
    // shift register and bit counter
    // ------------------------------------------------------------------
    logic [15:0] shift_ff;
    logic [4:0]  cnt_ff;
    logic        shift_en;
    assign shift_en = rx_en_ff & frame_open & sclk_rise;

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_ff <= 16'h0000;
        end else if (shift_en) begin
            shift_ff <= {shift_ff[14:0], sync_ff[2]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst || sync_fall || soft_rst) begin
            cnt_ff <= 5'h00;
        end else if (shift_en && cnt_ff != ddr_pkg::FULL_COUNT) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    logic execute;
    logic discard;
    assign execute = sync_rise & rx_en_ff & (cnt_ff == ddr_pkg::FULL_COUNT);
    assign discard = sync_rise & rx_en_ff & (cnt_ff != ddr_pkg::FULL_COUNT)
                     & (cnt_ff != 5'h00);

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    logic       w_ref;
    logic       w_load_both;
    logic       w_pd_a;
    logic       w_pd_b;
    logic       w_sel_b;
    logic [1:0] w_fn;
    logic [7:0] w_data;
    assign w_ref       = shift_ff[ddr_pkg::POS_REF_SEL];
    assign w_load_both = shift_ff[ddr_pkg::POS_LOAD_BOTH];
    assign w_pd_b      = shift_ff[ddr_pkg::POS_PD_B];
    assign w_pd_a      = shift_ff[ddr_pkg::POS_PD_A];
    assign w_sel_b     = shift_ff[ddr_pkg::POS_CHAN_SEL];
    assign w_fn        = {shift_ff[ddr_pkg::POS_FN_HI], shift_ff[ddr_pkg::POS_FN_LO]};
    assign w_data      = shift_ff[ddr_pkg::DATA_MSB:0];

    // ------------------------------------------------------------------
    // channel registers
    // ------------------------------------------------------------------
    logic [7:0] in_a_ff;
    logic [7:0] in_b_ff;
    logic [7:0] out_a_ff;
    logic [7:0] out_b_ff;
    logic [7:0] nxt_in_a;
    logic [7:0] nxt_in_b;
    logic [7:0] nxt_out_a;
    logic [7:0] nxt_out_b;
    always_comb begin
        nxt_in_a  = in_a_ff;
        nxt_in_b  = in_b_ff;
        nxt_out_a = out_a_ff;
        nxt_out_b = out_b_ff;
        if (w_load_both) begin
            // each output takes its own input register in the same step, the selected one the freshly loaded value
            if (w_sel_b) begin
                nxt_in_b = w_data;
            end else begin
                nxt_in_a = w_data;
            end
            nxt_out_a = w_sel_b ? in_a_ff : w_data;
            nxt_out_b = w_sel_b ? w_data : in_b_ff;
        end else begin
            case (w_fn)
                ddr_pkg::FN_BOTH_OUT_FROM_SHIFT: begin
                    nxt_out_a = w_data;
                    nxt_out_b = w_data;
                end
                ddr_pkg::FN_IN_FROM_SHIFT: begin
                    if (w_sel_b) begin
                        nxt_in_b = w_data;
                    end else begin
                        nxt_in_a = w_data;
                    end
                end
                ddr_pkg::FN_OUT_FROM_IN: begin
                    if (w_sel_b) begin
                        nxt_out_b = in_b_ff;
                    end else begin
                        nxt_out_a = in_a_ff;
                    end
                end
                ddr_pkg::FN_OUT_FROM_SHIFT: begin
                    if (w_sel_b) begin
                        nxt_out_b = w_data;
                    end else begin
                        nxt_out_a = w_data;
                    end
                end
                default: begin
                    nxt_out_a = out_a_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            in_a_ff  <= ddr_pkg::RST_CODE;
            in_b_ff  <= ddr_pkg::RST_CODE;
            out_a_ff <= ddr_pkg::RST_CODE;
            out_b_ff <= ddr_pkg::RST_CODE;
        end else if (execute) begin
            in_a_ff  <= nxt_in_a;
            in_b_ff  <= nxt_in_b;
            out_a_ff <= nxt_out_a;
            out_b_ff <= nxt_out_b;
        end
    end

    // ------------------------------------------------------------------
    // reference, power-down and transparency
    // ------------------------------------------------------------------
    logic ref_ff;
    logic pd_a_ff;
    logic pd_b_ff;
    logic transparent_ff;

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            ref_ff  <= 1'h0;
            pd_a_ff <= 1'h0;
            pd_b_ff <= 1'h0;
        end else if (execute) begin
            ref_ff  <= w_ref;
            pd_a_ff <= w_pd_a;
            pd_b_ff <= w_pd_b;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            transparent_ff <= ddr_pkg::RST_TRANSPARENT;
        end else if (execute) begin
            transparent_ff <= 1'h0;
        end
    end

    // power-down only gates the analog side; codes keep their value
    always_ff @(posedge clk) begin
        if (rst) begin
            dac_code_a        <= ddr_pkg::RST_CODE;
            dac_code_b        <= ddr_pkg::RST_CODE;
            reference_select  <= 1'h0;
            power_down_chan_a <= 1'h0;
            power_down_chan_b <= 1'h0;
        end else begin
            dac_code_a        <= transparent_ff ? in_a_ff : out_a_ff;
            dac_code_b        <= transparent_ff ? in_b_ff : out_b_ff;
            reference_select  <= ref_ff;
            power_down_chan_a <= pd_a_ff;
            power_down_chan_b <= pd_b_ff;
        end
    end

    // ------------------------------------------------------------------
    // status: short-frame flag and last accepted word
    // ------------------------------------------------------------------
    logic        short_ff;
    logic [15:0] last_word_ff;
    // a new discard wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            short_ff <= 1'h0;
        end else if (discard) begin
            short_ff <= 1'h1;
        end else if (wr_status && hwdata[ddr_pkg::STAT_SHORT]) begin
            short_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_word_ff <= 16'h0000;
        end else if (execute) begin
            last_word_ff <= shift_ff;
        end
    end

    // ------------------------------------------------------------------
    // read data, registered in the address phase
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        case (haddr[7:0])
            ddr_pkg::OFS_CTRL:      rd_mux = {31'h0, rx_en_ff};
            ddr_pkg::OFS_STATUS:    rd_mux = {23'h0, cnt_ff, 2'h0, short_ff, frame_open};
            ddr_pkg::OFS_INPUT:     rd_mux = {16'h0, in_b_ff, in_a_ff};
            ddr_pkg::OFS_OUTPUT:    rd_mux = {16'h0, out_b_ff, out_a_ff};
            ddr_pkg::OFS_CONFIG:    rd_mux = {28'h0, transparent_ff, pd_b_ff, pd_a_ff, ref_ff};
            ddr_pkg::OFS_LAST_WORD: rd_mux = {16'h0, last_word_ff};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

endmodule : ddr_frame_receiver

/* File: include/ddr_pkg.sv */
// shared constants of the dual converter serial frame receiver
package ddr_pkg;

    // ------------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS  = 5;
    localparam logic [4:0] FULL_COUNT = 5'h10;
    localparam int POS_REF_SEL  = 15;
    localparam int POS_LOAD_BOTH = 13;
    localparam int POS_PD_B     = 12;
    localparam int POS_PD_A     = 11;
    localparam int POS_CHAN_SEL = 10;
    localparam int POS_FN_HI    = 9;
    localparam int POS_FN_LO    = 8;
    localparam int DATA_MSB     = 7;

    // load function codes, load-both clear
    localparam logic [1:0] FN_BOTH_OUT_FROM_SHIFT = 2'h0;
    localparam logic [1:0] FN_IN_FROM_SHIFT       = 2'h1;
    localparam logic [1:0] FN_OUT_FROM_IN         = 2'h2;
    localparam logic [1:0] FN_OUT_FROM_SHIFT      = 2'h3;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_INPUT     = 8'h08;
    localparam logic [7:0] OFS_OUTPUT    = 8'h0C;
    localparam logic [7:0] OFS_CONFIG    = 8'h10;
    localparam logic [7:0] OFS_LAST_WORD = 8'h14;

    localparam int CTRL_RX_EN   = 0;
    localparam int CTRL_SOFT_RST = 1;
    localparam int STAT_OPEN    = 0;
    localparam int STAT_SHORT   = 1;
    localparam int STAT_CNT_LSB = 4;

    localparam logic       RST_RX_EN       = 1'h1;
    localparam logic [7:0] RST_CODE        = 8'h00;
    localparam logic       RST_TRANSPARENT = 1'h1;
    localparam logic [2:0] RST_PIN_LEVEL   = 3'h2;
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;

endpackage : ddr_pkg

/* File: verif/ddr_frame_receiver_sva.sv */
// assertion checker for the dual converter serial frame receiver
`timescale 1ns/1ps
module ddr_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sync_n,
    input wire logic [7:0]  dac_code_a,
    input wire logic [7:0]  dac_code_b,
    input wire logic        reference_select,
    input wire logic        power_down_chan_a,
    input wire logic        power_down_chan_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0]       rise_ff;
    logic [3:0]       wr_ff;
    logic             sync_d_ff;
    wire logic        req  = hsel && hready && htrans == 2'h2;
    wire logic        rd   = req && !hwrite;
    wire logic [18:0] outs = {dac_code_a, dac_code_b, reference_select,
                              power_down_chan_a, power_down_chan_b};
    // saturating ages give every output change a bounded window to its cause
    always_ff @(posedge clk) begin
        sync_d_ff <= sync_n;
        if (rst || (sync_n && !sync_d_ff)) rise_ff <= 4'h0;
        else if (rise_ff != 4'hF) rise_ff <= rise_ff + 4'h1;
        if (rst || (req && hwrite)) wr_ff <= 4'h0;
        else if (wr_ff != 4'hF) wr_ff <= wr_ff + 4'h1;
    end
    sequence s_idle4;
        sync_n[*4];
    endsequence
    property p_quiet; (!sync_n)[*8] |-> $stable(outs); endproperty
    a_quiet: assert property (p_quiet)
        else $error("outputs moved inside an open frame");
    property p_cause; $changed(outs) |-> rise_ff <= 4'h8 || wr_ff <= 4'h4; endproperty
    a_cause: assert property (p_cause)
        else $error("outputs moved with no frame end");
    property p_rst; disable iff (1'b0) rst |=> outs == 19'h0 && hrdata == 32'h0; endproperty
    a_rst: assert property (p_rst)
        else $error("reset did not clear outputs");
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay)
        else $error("bus slave stalled or erred");
    property p_unmapped; rd && haddr[7:0] > 8'h14 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_cfg;
        rd && haddr[7:0] == 8'h10 && rise_ff == 4'hF && wr_ff == 4'hF
            |=> hrdata[2:0] == {power_down_chan_b, power_down_chan_a, reference_select};
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config read disagrees with pins");
    property p_idle; s_idle4 ##0 (rd && haddr[7:0] == 8'h04) |=> !hrdata[0]; endproperty
    a_idle: assert property (p_idle)
        else $error("frame shown open while select high");
    property p_stat; rd && haddr[7:0] == 8'h04 |=> hrdata[31:9] == 23'h0; endproperty
    a_stat: assert property (p_stat)
        else $error("status upper bits not zero");
    c_end: cover property ($rose(sync_n));
    c_pd: cover property (power_down_chan_a && power_down_chan_b);
    c_ref: cover property ($rose(reference_select));
endmodule : ddr_chk

bind ddr_frame_receiver ddr_chk u_chk (.clk(clk), .rst(rst), .sync_n(sync_n),
    .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .reference_select(reference_select),
    .power_down_chan_a(power_down_chan_a), .power_down_chan_b(power_down_chan_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* File: verif/ddr_host_model.sv */
// host serial port model driving frame select, serial clock and data
`timescale 1ns/1ps
module ddr_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      sync_n,
    output logic      din
);
    initial begin
        sclk   = 1'b0;
        sync_n = 1'b1;
        din    = 1'b0;
    end
    // sends the top n bits msb first; open low keeps frame select high,
    // split adds a pause after the control byte with the frame held open
    task automatic send(input logic [15:0] w, input int n, input bit open, input bit split);
        @(posedge clk);
        sync_n <= !open;
        repeat (3) @(posedge clk);
        for (int i = 15; i > 15 - n; i--) begin
            din <= w[i];
            repeat (2) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
            if (split && i == 8) repeat (6) @(posedge clk);
        end
        repeat (2) @(posedge clk);
        sync_n <= 1'b1;
        din    <= !din;
        repeat (4) @(posedge clk);
    endtask : send
endmodule : ddr_host_model

/* File: verif/testbench.sv */
// self-checking bench for the dual converter serial frame receiver
`timescale 1ns/1ps
module testbench;
    logic              clk, rst, hsel, hwrite, look, rd_dp, tr, en;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata;
    logic [31:0]       exp_q[$];
    logic [7:0]        in_a, in_b, out_a, out_b;
    logic              m_ref, m_pda, m_pdb;
    logic [15:0]       last_w;
    int                fails, num_checks, cyc;
    logic [7:0]        ctl[11];
    wire logic         sclk, sync_n, din, hreadyout, hresp, ref_sel, pd_a, pd_b;
    wire logic [7:0]   code_a, code_b;
    wire logic [31:0]  hrdata;
    wire logic [31:0]  pins = {13'h0, code_a, code_b, ref_sel, pd_a, pd_b};
    ddr_host_model host (.clk(clk), .sclk(sclk), .sync_n(sync_n), .din(din));
    ddr_frame_receiver uut (.clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .din(din),
        .dac_code_a(code_a), .dac_code_b(code_b), .reference_select(ref_sel),
        .power_down_chan_a(pd_a), .power_down_chan_b(pd_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    always #5 clk = !clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : chk
    // results are matched in issue order as they appear on the ports
    always @(posedge clk) begin
        cyc++;
        if (rd_dp || look) chk(look ? pins : hrdata, exp_q.pop_front());
        rd_dp <= hsel && hreadyout && htrans == ddr_pkg::HTRANS_NONSEQ && !hwrite;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= 3'h2;
        htrans <= ddr_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic verify;
        exp_q.push_back({13'h0, tr ? in_a : out_a, tr ? in_b : out_b, m_ref, m_pda, m_pdb});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
        rd(8'h08, {16'h0, in_b, in_a});
        rd(8'h0C, {16'h0, out_b, out_a});
        rd(8'h10, {28'h0, tr, m_pdb, m_pda, m_ref});
        if (!tr) rd(8'h14, {16'h0, last_w});
    endtask : verify
    task automatic frame(input logic [7:0] c, input int n, input bit open, input bit split);
        logic [15:0] w;
        logic [7:0]  dv;
        dv = 8'($urandom());
        w  = {c, dv};
        host.send(w, n, open, split);
        repeat (20) @(posedge clk);
        if (n == 16 && open && en) begin
            last_w = w;
            {m_ref, m_pdb, m_pda} = {w[15], w[12], w[11]};
            tr = 1'b0;
            if (w[ddr_pkg::POS_LOAD_BOTH]) begin
                if (w[10]) in_b = dv; else in_a = dv;
                {out_a, out_b} = {in_a, in_b};
            end else case (w[9:8])
                ddr_pkg::FN_BOTH_OUT_FROM_SHIFT: {out_a, out_b} = {dv, dv};
                ddr_pkg::FN_IN_FROM_SHIFT: if (w[10]) in_b = dv; else in_a = dv;
                ddr_pkg::FN_OUT_FROM_IN: if (w[10]) out_b = in_b; else out_a = in_a;
                default: if (w[10]) out_b = dv; else out_a = dv;
            endcase
        end
        verify();
    endtask : frame
    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        {clk, rst, hsel, hwrite, look, rd_dp, tr, en} = 8'h63;
        {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
        {in_a, in_b, out_a, out_b, m_ref, m_pda, m_pdb, last_w} = 51'h0;
        {fails, num_checks, cyc} = 0;
        void'($urandom(32'h01216EEC));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h40, 32'h0);
        bus(8'h40, 1'b1, $urandom());
        verify();
        ctl = '{8'h01, 8'h05, 8'h02, 8'h07, 8'h00, 8'h20, 8'h24, 8'h99, 8'h8A, 8'h43, 8'h9E};
        foreach (ctl[i]) frame(ctl[i], 16, 1'b1, i[0]);
        frame(8'h87, 9, 1'b1, 1'b0);
        rd(8'h04, 32'h92);
        bus(8'h04, 1'b1, 32'h2);
        rd(8'h04, 32'h90);
        frame(8'h83, 16, 1'b0, 1'b0);
        bus(8'h00, 1'b1, 32'h0);
        en = 1'b0;
        frame(8'h83, 16, 1'b1, 1'b0);
        bus(8'h00, 1'b1, 32'h3);
        {en, tr, in_a, in_b, out_a, out_b, m_ref, m_pda, m_pdb} = {2'h3, 35'h0};
        repeat (4) @(posedge clk);
        verify();
        rd(8'h04, 32'h0);
        complete_run();
    end
endmodule : testbench
